// ### hdl/pcc_edge_counter.v
// pixel clock rise detector, sampled on the reference clock

module pcc_edge_counter (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // sampled pixel clock
  input wire pix_in,
  // high in each cycle whose sample shows a rise
  output wire pix_rise
);

  reg pix_prev_q;

  // pixel clock must stay below half of REF_CLK or edges are missed
  assign pix_rise = pix_in & ~pix_prev_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pix_prev_q <= 1'b0;
    end
    else
    begin
      pix_prev_q <= pix_in;
    end
  end

endmodule

// ### hdl/pcc_map.vh
// register map, field positions and timing constants for the meter and caps
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// register offsets on the configuration port
`define PCC_ADDR_EDGE_METER 8'h1f
`define PCC_ADDR_PEER_CAPS 8'h20
`define PCC_ADDR_PEER_CAPS2 8'h21

// reset values
`define PCC_RST_EDGE_METER 8'h00
`define PCC_RST_PEER_CAPS 8'h00
`define PCC_RST_PEER_CAPS2 8'h00
`define PCC_READ_ZERO 8'h00

// field positions in peer_capability_flags
`define PCC_BIT_HOLD 7
`define PCC_BIT_RSVD 6
`define PCC_BIT_FREQ_TRAIN 5
`define PCC_BIT_EQ_TRAIN 4
`define PCC_BIT_TWO_LINK 3
`define PCC_BIT_CHANNEL 2
`define PCC_BIT_WIDE_VIDEO 1
`define PCC_BIT_FWD_GPIO 0
`define PCC_CAP_MSB 5
`define PCC_CAP_WIDTH 6

// edge count saturation value
`define PCC_COUNT_MAX 8'hff
`define PCC_COUNT_ONE 8'h01
`define PCC_COUNT_ZERO 8'h00

// interval unit is one oscillator period, counted in REF_CLK cycles
`define PCC_OSC_PERIOD_NS 40
`define PCC_CLK_PERIOD_NS 10
`define PCC_TICKS_PER_OSC (`PCC_OSC_PERIOD_NS / `PCC_CLK_PERIOD_NS)
`define PCC_TICK_WIDTH 10
`define PCC_TICK_ONE 10'h001
`define PCC_TICK_ZERO 10'h000

`endif

// ### hdl/pcc_regs.v
// edge meter and peer capability registers with control channel loading
//
// How it works
// - A nonzero write to the edge meter register starts counting pixel clock edges.
// - The window lasts the written value times the 40 ns oscillator period.
// - A read of the edge meter returns the edges seen in the last window.
// - The edge count sticks at all ones instead of wrapping.
// - With the hold bit set the channel leaves the capability fields alone.
// - With the hold bit clear the channel loads the fields once rx locked.
// - Capability bit 5 drives the frequency training request to the link.
// - Capability bit 4 drives the equalization training request.
// - Capability bit 3 tells whether the peer can run over two links.
// - Capability bit 2 gives the channel role, zero primary, one secondary.
// - Capability bit 1 flags wide video with hd audio, channel loaded.
// - Capability bit 0 flags forward gpio support, channel loaded.
`include "pcc_map.vh"

module pcc_regs (
  // clock and reset
  input wire REF_CLK,
  input wire RST_B,
  // configuration port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  // pixel clock, sampled on REF_CLK
  input wire PIXEL_CLK,
  // control channel side
  input wire RX_LOCK,
  input wire BCC_CAP_VALID,
  input wire [5:0] BCC_CAP,
  // measurement status
  output wire MEAS_BUSY,
  output wire MEAS_DONE,
  // capability outputs
  output wire HOLD_PEER_CAPABILITIES,
  output wire REQUEST_FREQ_TRAINING,
  output wire REQUEST_EQ_TRAINING,
  output wire PEER_TWO_LINK_CAPABLE,
  output wire PEER_CHANNEL_SECONDARY,
  output wire PEER_WIDE_VIDEO_WITH_HD_AUDIO,
  output wire PEER_FORWARD_GPIO_SUPPORT
);

  localparam [7:0] caps_rst = `PCC_RST_PEER_CAPS;
  localparam [1:0] st_idle = 2'b01;
  localparam [1:0] st_run = 2'b10;

  reg hold_q;
  reg [`PCC_CAP_MSB:0] cap_q;
  wire meter_wr;
  wire caps_wr;
  wire chan_load;
  wire pix_rise;
  wire [31:0] span;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`PCC_TICK_WIDTH-1:0] tick_q;
  reg [`PCC_TICK_WIDTH-1:0] tick_d;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg busy_q;
  reg done_q;
  wire [7:0] caps_view;
  reg [7:0] rdata_d;

  // address decode
  assign meter_wr = REG_WR && (REG_ADDR == `PCC_ADDR_EDGE_METER);
  assign caps_wr = REG_WR && (REG_ADDR == `PCC_ADDR_PEER_CAPS);

  // channel updates count only with lock and no hold from software
  assign chan_load = BCC_CAP_VALID && RX_LOCK && !hold_q;

  // a full 255 unit window still fits the tick counter
  assign span = REG_WDATA * `PCC_TICKS_PER_OSC;

  pcc_edge_counter u_pix_edge (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pix_in(PIXEL_CLK),
    .pix_rise(pix_rise)
  );

  always @*
  begin
    state_d = state_q;
    tick_d = tick_q;
    count_d = count_q;
    case (state_q)
      st_idle:
      begin
        tick_d = `PCC_TICK_ZERO;
      end
      st_run:
      begin
        if (pix_rise && count_q != `PCC_COUNT_MAX)
        begin
          count_d = count_q + `PCC_COUNT_ONE;
        end
        tick_d = tick_q - `PCC_TICK_ONE;
        if (tick_q == `PCC_TICK_ONE)
        begin
          state_d = st_idle;
        end
      end
      default:
      begin
        state_d = st_idle;
      end
    endcase
    // a restart throws away the running window and its count
    if (meter_wr)
    begin
      count_d = `PCC_COUNT_ZERO;
      tick_d = span[`PCC_TICK_WIDTH-1:0];
      if (REG_WDATA != `PCC_COUNT_ZERO)
      begin
        state_d = st_run;
      end
      else
      begin
        state_d = st_idle;
      end
    end
  end

  // busy and done follow the next state so the ports come from flops;
  // an aborted window never reports done
  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q <= st_idle;
      tick_q <= `PCC_TICK_ZERO;
      count_q <= `PCC_RST_EDGE_METER;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= tick_d;
      count_q <= count_d;
      busy_q <= (state_d == st_run);
      done_q <= (state_q == st_run) && (state_d == st_idle) && !meter_wr;
    end
  end

  // hold bit is software owned only
  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hold_q <= caps_rst[`PCC_BIT_HOLD];
    end
    else if (caps_wr)
    begin
      hold_q <= REG_WDATA[`PCC_BIT_HOLD];
    end
  end

  // a software write in the same cycle as a channel load wins, so an
  // override written together with hold is never lost
  genvar i;
  generate
    for (i = 0; i < `PCC_CAP_WIDTH; i = i + 1)
    begin : g_cap
      always @(posedge REF_CLK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          cap_q[i] <= caps_rst[i];
        end
        else if (caps_wr)
        begin
          cap_q[i] <= REG_WDATA[i];
        end
        else if (chan_load)
        begin
          cap_q[i] <= BCC_CAP[i];
        end
      end
    end
  endgenerate

  assign caps_view = {hold_q, 1'b0, cap_q};

  // register read, one cycle latency; unmapped and reserved read zero
  always @*
  begin
    rdata_d = `PCC_READ_ZERO;
    if (REG_ADDR == `PCC_ADDR_EDGE_METER)
    begin
      rdata_d = count_q;
    end
    else if (REG_ADDR == `PCC_ADDR_PEER_CAPS)
    begin
      rdata_d = caps_view;
    end
    else if (REG_ADDR == `PCC_ADDR_PEER_CAPS2)
    begin
      rdata_d = `PCC_RST_PEER_CAPS2;
    end
  end

  always @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REG_RDATA <= `PCC_READ_ZERO;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
      begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  assign MEAS_BUSY = busy_q;
  assign MEAS_DONE = done_q;

  // capability bits go straight out of their flops
  assign HOLD_PEER_CAPABILITIES = hold_q;
  assign REQUEST_FREQ_TRAINING = cap_q[`PCC_BIT_FREQ_TRAIN];
  assign REQUEST_EQ_TRAINING = cap_q[`PCC_BIT_EQ_TRAIN];
  assign PEER_TWO_LINK_CAPABLE = cap_q[`PCC_BIT_TWO_LINK];
  assign PEER_CHANNEL_SECONDARY = cap_q[`PCC_BIT_CHANNEL];
  assign PEER_WIDE_VIDEO_WITH_HD_AUDIO = cap_q[`PCC_BIT_WIDE_VIDEO];
  assign PEER_FORWARD_GPIO_SUPPORT = cap_q[`PCC_BIT_FWD_GPIO];

endmodule

// ### verif/pcc_peer_model.sv
// remote end of the control channel: lock level and capability updates
module pcc_peer_model (
  input wire logic clk,
  input wire logic lock_en,
  input wire logic send,
  input wire logic [5:0] caps,
  output logic lock = 1'b0,
  output logic valid = 1'b0,
  output logic [5:0] cap = 6'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // cap lines carry junk outside an update, so show the inverse
  always @(posedge clk)
  begin
    lock <= lock_en;
    valid <= send;
    cap <= send ? caps : ~caps;
  end
endmodule

// ### verif/pcc_regs_sva.sv
// concurrent checks on the meter and capability register block
module pcc_sva_chk (
  input wire REF_CLK,
  input wire RST_B,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire REG_RD,
  input wire REG_RVALID,
  input wire RX_LOCK,
  input wire BCC_CAP_VALID,
  input wire [5:0] BCC_CAP,
  input wire MEAS_BUSY,
  input wire MEAS_DONE,
  input wire HOLD_PEER_CAPABILITIES,
  input wire REQUEST_FREQ_TRAINING,
  input wire REQUEST_EQ_TRAINING
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  wire m_wr = REG_WR && REG_ADDR == 8'h1f;
  wire c_ld = BCC_CAP_VALID && RX_LOCK && !HOLD_PEER_CAPABILITIES && !REG_WR;
  wire w7 = REG_WDATA[7];
  wire [1:0] c54 = BCC_CAP[5:4];
  wire [1:0] trn = {REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING};
  rd_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read gave no valid");
  meas_start_a: assert property (m_wr && REG_WDATA != 8'h00
    |=> MEAS_BUSY && !MEAS_DONE) else $error("window not started");
  zero_len_a: assert property (m_wr && REG_WDATA == 8'h00
    |=> !MEAS_BUSY && !MEAS_DONE) else $error("empty window ran");
  unit_len_a: assert property (m_wr && REG_WDATA == 8'h01
    ##1 !m_wr [*4] |=> MEAS_DONE) else $error("window length off");
  done_end_a: assert property (MEAS_DONE |-> !MEAS_BUSY
    && $past(MEAS_BUSY)) else $error("done without window");
  hold_keep_a: assert property (HOLD_PEER_CAPABILITIES && !REG_WR
    |=> $stable(trn)) else $error("held caps changed");
  cap_load_a: assert property (c_ld |=> trn == $past(c54))
    else $error("caps not loaded");
  sw_hold_a: assert property (REG_WR && REG_ADDR == 8'h20
    |=> HOLD_PEER_CAPABILITIES == $past(w7)) else $error("hold not set");
  cover property ($fell(MEAS_BUSY));
  cover property (c_ld);
  cover property (BCC_CAP_VALID && HOLD_PEER_CAPABILITIES);
endmodule

bind pcc_regs pcc_sva_chk i_chk (.*);

// ### verif/tb_top.sv
// self-checking bench for the edge meter and peer capability registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0, RST_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic PIXEL_CLK = 1'b0, lk = 1'b0, snd = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  logic [5:0] cv = 6'h00;
  logic [1:0] ph = 2'h0;
  wire RX_LOCK, BCC_CAP_VALID, REG_RVALID, MEAS_BUSY, MEAS_DONE;
  wire [5:0] BCC_CAP;
  wire [7:0] REG_RDATA;
  wire HOLD_PEER_CAPABILITIES, REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING;
  wire PEER_TWO_LINK_CAPABLE, PEER_CHANNEL_SECONDARY;
  wire PEER_WIDE_VIDEO_WITH_HD_AUDIO, PEER_FORWARD_GPIO_SUPPORT;
  int n_mismatch = 0, cmp_count = 0, k;
  wire [5:0] caps_out = {REQUEST_FREQ_TRAINING, REQUEST_EQ_TRAINING,
    PEER_TWO_LINK_CAPABLE, PEER_CHANNEL_SECONDARY,
    PEER_WIDE_VIDEO_WITH_HD_AUDIO, PEER_FORWARD_GPIO_SUPPORT};
  always #5 REF_CLK = ~REF_CLK;
  // a third of the sample rate: exactly one rise per three cycles
  always @(posedge REF_CLK)
  begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    PIXEL_CLK <= (ph == 2'h1);
  end
  pcc_regs i_dut (.*);
  pcc_peer_model i_peer (.clk(REF_CLK), .lock_en(lk), .send(snd),
    .caps(cv), .lock(RX_LOCK), .valid(BCC_CAP_VALID), .cap(BCC_CAP));
  task chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    @(posedge REF_CLK);
    #1 chk(REG_RDATA, e);
  endtask
  // four sample cycles per oscillator period of the window
  task meas(input logic [7:0] n, e, input logic [15:0] len);
    int b;
    b = 0;
    wr(8'h1f, n);
    // busy is launched on the write edge itself, so count from there
    #1;
    for (k = 0; k < 1100 && MEAS_DONE !== 1'b1; k++)
    begin
      b += (MEAS_BUSY === 1'b1);
      @(posedge REF_CLK);
      #1;
    end
    chk(MEAS_DONE, 1'b1);
    chk(16'(b), len);
    rd(8'h1f, e);
  endtask
  task peer(input logic l, input logic [5:0] c);
    @(posedge REF_CLK);
    lk <= l;
    cv <= c;
    snd <= 1'b1;
    @(posedge REF_CLK);
    snd <= 1'b0;
    repeat (2) @(posedge REF_CLK);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1'b1;
    rd(8'h1f, 8'h00);
    rd(8'h20, 8'h00);
    $display("reset test done");
    meas(8'h03, 8'h04, 16'h000c);
    wr(8'h1f, 8'h06);
    repeat (5) @(posedge REF_CLK);
    meas(8'h03, 8'h04, 16'h000c);
    meas(8'hff, 8'hff, 16'h03fc);
    wr(8'h1f, 8'h00);
    rd(8'h1f, 8'h00);
    $display("meter test done");
    for (int i = 0; i < 6; i++)
    begin
      peer(1'b1, 6'h01 << i);
      rd(8'h20, 8'h01 << i);
      chk(caps_out, 6'h01 << i);
    end
    peer(1'b0, 6'h3f);
    rd(8'h20, 8'h20);
    wr(8'h20, 8'hd5);
    peer(1'b1, 6'h2a);
    rd(8'h20, 8'h95);
    chk(REQUEST_EQ_TRAINING, 1'b1);
    chk(caps_out, 6'h15);
    wr(8'h21, 8'hff);
    rd(8'h21, 8'h00);
    $display("caps test done");
    summarize;
  end
  initial
  begin
    repeat (4000) @(posedge REF_CLK);
    n_mismatch++;
    summarize;
  end
endmodule
